/* File: hw/pwk_pkg.sv */
// Constants, register map and state type of the power and wake controller.
package pwk_pkg;

	// Register indices; the byte address is four times the index.
	localparam logic [15:0] IDX_CPU_POWER_CONTROL = 16'h0087;
	localparam logic [15:0] IDX_INTERRUPT_SOURCE_1 = 16'h7f02;
	localparam logic [15:0] IDX_WAKE_FLAGS_BANK_A = 16'h7f2a;
	localparam logic [15:0] IDX_WAKE_FLAGS_BANK_B = 16'h7f2b;
	localparam logic [15:0] IDX_WAKE_FLAGS_HOST_PINS = 16'h7f55;
	localparam logic [15:0] IDX_WAKE_FLAGS_PINS_LOW = 16'h7f59;
	localparam logic [15:0] IDX_WAKE_FLAGS_PINS_MID = 16'h7f5e;
	localparam logic [15:0] IDX_WAKE_FLAGS_PINS_HIGH = 16'h7f63;
	localparam logic [15:0] IDX_WAKE_FLAGS_FAN = 16'h7f64;
	localparam logic [15:0] IDX_CLOCK_SELECT_CONTROL = 16'h7f10;
	localparam logic [15:0] IDX_SLEEP_ENTRY_FLAG = 16'h7f11;
	localparam logic [15:0] IDX_WAKE_ENABLE = 16'h7f12;
	localparam logic [15:0] IDX_PIN_EDGE_SELECT = 16'h7f13;
	localparam logic [15:0] IDX_POWER_STATUS = 16'h7f14;

	// Field positions.
	localparam int IDLE_BIT = 0;
	localparam int RING_EN_BIT = 4;
	localparam int EXT_SRC_BIT = 5;
	localparam int RTC_ALARM_BIT = 0;
	localparam int ANY_KEY_BIT = 1;
	localparam int HIB_TIMER_BIT = 2;
	localparam int SMBUS2_BIT = 3;
	localparam int SMBUS1_BIT = 4;
	localparam int ACPI_STATUS_BIT = 5;
	localparam int ACPI_ENABLE_BIT = 6;
	localparam int ACPI_CONTROL_BIT = 7;
	localparam int FAN1_BIT = 0;
	localparam int FAN2_BIT = 1;
	localparam int PIN3_INT_BIT = 3;

	// Wake enable bits, one per flag register.
	localparam int EN_A = 0;
	localparam int EN_B = 1;
	localparam int EN_HOST = 2;
	localparam int EN_LOW = 3;
	localparam int EN_MID = 4;
	localparam int EN_HIGH = 5;
	localparam int EN_FAN = 6;
	localparam int EN_INT = 7;

	// Reset values.
	localparam logic [7:0] RST_CPU_POWER_CONTROL = 8'h00;
	localparam logic [7:0] RST_CLOCK_SELECT = 8'h20;
	localparam logic [7:0] RST_WAKE_ENABLE = 8'hff;
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [21:0] RST_EDGE_SELECT = 22'h000000;

	// Pin map: {register, bit}; register 0 low, 1 mid, 2 high, 3 int.
	localparam int NPINS = 22;
	localparam logic [1:0] MAP_LOW = 2'd0;
	localparam logic [1:0] MAP_MID = 2'd1;
	localparam logic [1:0] MAP_HIGH = 2'd2;
	localparam logic [1:0] MAP_INT = 2'd3;
	localparam logic [NPINS-1:0][4:0] PIN_MAP = {
		{MAP_HIGH, 3'd6}, {MAP_HIGH, 3'd5}, {MAP_HIGH, 3'd4},
		{MAP_HIGH, 3'd7}, {MAP_HIGH, 3'd3}, {MAP_HIGH, 3'd2},
		{MAP_HIGH, 3'd1}, {MAP_HIGH, 3'd0}, {MAP_MID, 3'd7},
		{MAP_MID, 3'd6}, {MAP_MID, 3'd5}, {MAP_MID, 3'd4},
		{MAP_MID, 3'd3}, {MAP_MID, 3'd2}, {MAP_LOW, 3'd6},
		{MAP_MID, 3'd1}, {MAP_MID, 3'd0}, {MAP_LOW, 3'd7},
		{MAP_INT, 3'd3}, {MAP_LOW, 3'd4}, {MAP_LOW, 3'd3},
		{MAP_LOW, 3'd2}
	};

	// Synchroniser layout of the pin inputs.
	localparam int NSYNC = 37;
	localparam int S_SMB1 = 0;
	localparam int S_SMB2 = 1;
	localparam int S_KSI = 2;
	localparam int S_GPIO = 10;
	localparam int S_HOST = 32;
	localparam int S_MAIN = 36;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam logic [1:0] RESP_DECERR = 2'b11;

	typedef enum logic [3:0] {
		ST_RUN = 4'b0001,
		ST_IDLE = 4'b0010,
		ST_SLEEP = 4'b0100,
		ST_WAKE = 4'b1000
	} pwk_state_t;

	typedef struct packed {
		pwk_state_t st;
		logic aw_held;
		logic w_held;
		logic [15:0] aw_idx;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic arready;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] cpu_power_control;
		logic [7:0] clksel;
		logic sleep_entry_flag;
		logic [7:0] wake_en;
		logic [21:0] edge_sel;
		logic [7:0] intsrc;
		logic [7:0] fl_a;
		logic [7:0] fl_b;
		logic [7:0] fl_host;
		logic [7:0] fl_low;
		logic [7:0] fl_mid;
		logic [7:0] fl_high;
		logic [7:0] fl_fan;
		logic [NSYNC-1:0] s1;
		logic [NSYNC-1:0] s2;
		logic [NSYNC-1:0] s3;
		logic core_clk_en;
		logic periph_clk_en;
		logic ring_osc_en;
		logic xtal_osc_en;
		logic pin_hold;
	} pwk_regs_t;

endpackage : pwk_pkg

/* File: hw/pwk_power_wake.sv */
// Power-mode sequencer, wake flag registers and AXI4-Lite slave.
//
// Added by the designer: the AXI4-Lite slave port.
module pwk_power_wake
	import pwk_pkg::*;
#(
	parameter int ADDR_W = 18
) (
	// Clock and standby power-on reset.
	input wire logic clk_i,
	input wire logic rstn_i,
	// AXI4-Lite slave.
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// Core interrupt logic, same clock.
	input wire logic enabled_irq_i,
	// Internal wake sources, same clock, active high.
	input wire logic rtc_alarm_wake_i,
	input wire logic hibernation_timer_wake_i,
	input wire logic acpi_status_wake_i,
	input wire logic acpi_enable_wake_i,
	input wire logic acpi_control_wake_i,
	input wire logic fan1_slow_wake_i,
	input wire logic fan2_slow_wake_i,
	// Wake pins and main supply good, asynchronous.
	input wire logic smbus1_data_pin_i,
	input wire logic smbus2_data_pin_i,
	input wire logic [7:0] key_scan_inputs_i,
	input wire logic [NPINS-1:0] gpio_pins_i,
	input wire logic [3:0] host_pins_i,
	input wire logic main_supply_good_i,
	// Clock and power controls.
	output logic core_clk_en_o,
	output logic periph_clk_en_o,
	output logic ring_osc_en_o,
	output logic xtal_osc_en_o,
	output logic clk_src_ext_o,
	output logic pin_hold_o,
	output logic idle_o,
	output logic sleep_o
);

	pwk_regs_t r_r;
	pwk_regs_t r_nxt;

	function automatic logic [15:0] addr_idx(input logic [ADDR_W-1:0] a);
		addr_idx = a[17:2];
	endfunction : addr_idx

	function automatic logic known_idx(input logic [15:0] i);
		case (i)
			IDX_CPU_POWER_CONTROL, IDX_INTERRUPT_SOURCE_1,
			IDX_WAKE_FLAGS_BANK_A, IDX_WAKE_FLAGS_BANK_B,
			IDX_WAKE_FLAGS_HOST_PINS, IDX_WAKE_FLAGS_PINS_LOW,
			IDX_WAKE_FLAGS_PINS_MID, IDX_WAKE_FLAGS_PINS_HIGH,
			IDX_WAKE_FLAGS_FAN, IDX_CLOCK_SELECT_CONTROL,
			IDX_SLEEP_ENTRY_FLAG, IDX_WAKE_ENABLE,
			IDX_PIN_EDGE_SELECT, IDX_POWER_STATUS: known_idx = 1'b1;
			default: known_idx = 1'b0;
		endcase
	endfunction : known_idx

	function automatic logic [31:0] read_idx(input pwk_regs_t r,
			input logic [15:0] i);
		case (i)
			IDX_CPU_POWER_CONTROL: read_idx = {24'h000000, r.cpu_power_control};
			IDX_INTERRUPT_SOURCE_1: read_idx = {24'h000000, r.intsrc};
			IDX_WAKE_FLAGS_BANK_A: read_idx = {24'h000000, r.fl_a};
			IDX_WAKE_FLAGS_BANK_B: read_idx = {24'h000000, r.fl_b};
			IDX_WAKE_FLAGS_HOST_PINS: read_idx = {24'h000000, r.fl_host};
			IDX_WAKE_FLAGS_PINS_LOW: read_idx = {24'h000000, r.fl_low};
			IDX_WAKE_FLAGS_PINS_MID: read_idx = {24'h000000, r.fl_mid};
			IDX_WAKE_FLAGS_PINS_HIGH: read_idx = {24'h000000, r.fl_high};
			IDX_WAKE_FLAGS_FAN: read_idx = {24'h000000, r.fl_fan};
			IDX_CLOCK_SELECT_CONTROL: read_idx = {24'h000000, r.clksel};
			IDX_SLEEP_ENTRY_FLAG:
				read_idx = {31'h00000000, r.sleep_entry_flag};
			IDX_WAKE_ENABLE: read_idx = {24'h000000, r.wake_en};
			IDX_PIN_EDGE_SELECT: read_idx = {10'h000, r.edge_sel};
			IDX_POWER_STATUS:
				read_idx = {27'h0000000, r.s2[S_MAIN], r.st};
			default: read_idx = 32'h00000000;
		endcase
	endfunction : read_idx

	// Write-one-to-clear on byte lane 0.
	function automatic logic [7:0] w1c(input logic [7:0] old,
			input logic [31:0] d, input logic [3:0] s);
		w1c = old & ~(d[7:0] & {8{s[0]}});
	endfunction : w1c

	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] d, input logic [3:0] s);
		logic [31:0] m;
		m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		merge = (old & ~m) | (d & m);
	endfunction : merge

	// Per-pin edge events steered into their flag registers.
	logic [NPINS-1:0] pin_rise;
	logic [NPINS-1:0] pin_fall;
	logic [NPINS-1:0] pin_evt;
	logic [7:0] set_low;
	logic [7:0] set_mid;
	logic [7:0] set_high;
	logic [7:0] set_int;

	assign pin_rise = r_r.s2[S_GPIO +: NPINS] & ~r_r.s3[S_GPIO +: NPINS];
	assign pin_fall = ~r_r.s2[S_GPIO +: NPINS] & r_r.s3[S_GPIO +: NPINS];
	// The pin is sampled whatever function drives it.
	assign pin_evt = (pin_rise & r_r.edge_sel) |
		(pin_fall & ~r_r.edge_sel);

	always_comb begin
		set_low = 8'h00;
		set_mid = 8'h00;
		set_high = 8'h00;
		set_int = 8'h00;
		for (int p = 0; p < NPINS; p++) begin
			case (PIN_MAP[p][4:3])
				MAP_LOW: set_low[PIN_MAP[p][2:0]] =
					set_low[PIN_MAP[p][2:0]] | pin_evt[p];
				MAP_MID: set_mid[PIN_MAP[p][2:0]] =
					set_mid[PIN_MAP[p][2:0]] | pin_evt[p];
				MAP_HIGH: set_high[PIN_MAP[p][2:0]] =
					set_high[PIN_MAP[p][2:0]] | pin_evt[p];
				default: set_int[PIN_MAP[p][2:0]] =
					set_int[PIN_MAP[p][2:0]] | pin_evt[p];
			endcase
		end
	end

	logic [7:0] set_a;
	logic [7:0] set_b;
	logic [7:0] set_host;
	logic [7:0] set_fan;
	logic [3:0] host_edge;

	assign host_edge = r_r.s2[S_HOST +: 4] ^ r_r.s3[S_HOST +: 4];

	always_comb begin
		set_a = 8'h00;
		set_a[ACPI_STATUS_BIT] = acpi_status_wake_i;
		set_a[ACPI_ENABLE_BIT] = acpi_enable_wake_i;
		set_a[ACPI_CONTROL_BIT] = acpi_control_wake_i;
		set_a[SMBUS1_BIT] = r_r.s3[S_SMB1] & ~r_r.s2[S_SMB1];
		set_a[SMBUS2_BIT] = r_r.s3[S_SMB2] & ~r_r.s2[S_SMB2];
		set_b = 8'h00;
		set_b[RTC_ALARM_BIT] = rtc_alarm_wake_i;
		set_b[HIB_TIMER_BIT] = hibernation_timer_wake_i;
		set_b[ANY_KEY_BIT] = |(r_r.s3[S_KSI +: 8] &
			~r_r.s2[S_KSI +: 8]);
		set_host = {4'h0, host_edge};
		set_fan = 8'h00;
		set_fan[FAN1_BIT] = fan1_slow_wake_i;
		set_fan[FAN2_BIT] = fan2_slow_wake_i;
	end

	// Wake request: any flag in an enabled register.
	logic wake_req;

	assign wake_req = (r_r.wake_en[EN_A] & |r_r.fl_a) |
		(r_r.wake_en[EN_B] & |r_r.fl_b) |
		(r_r.wake_en[EN_HOST] & |r_r.fl_host) |
		(r_r.wake_en[EN_LOW] & |r_r.fl_low) |
		(r_r.wake_en[EN_MID] & |r_r.fl_mid) |
		(r_r.wake_en[EN_HIGH] & |r_r.fl_high) |
		(r_r.wake_en[EN_FAN] & |r_r.fl_fan) |
		(r_r.wake_en[EN_INT] & r_r.intsrc[PIN3_INT_BIT]);

	logic do_write;
	logic wr_ok;
	logic main_ok;
	logic [15:0] ar_idx;

	assign main_ok = r_r.s2[S_MAIN];
	assign do_write = r_r.aw_held & r_r.w_held & ~r_r.bvalid;
	// Host-pin flags live in the main domain.
	assign wr_ok = known_idx(r_r.aw_idx) & (main_ok |
		(r_r.aw_idx != IDX_WAKE_FLAGS_HOST_PINS));
	assign ar_idx = addr_idx(s_axi_araddr_i);

	always_comb begin
		r_nxt = r_r;
		// Pins pass two flops before use; s3 holds the prior sample.
		r_nxt.s1 = {main_supply_good_i, host_pins_i, gpio_pins_i,
			key_scan_inputs_i, smbus2_data_pin_i, smbus1_data_pin_i};
		r_nxt.s2 = r_r.s1;
		r_nxt.s3 = r_r.s2;

		// Write address and data are taken in either order.
		if (s_axi_awvalid_i && r_r.awready) begin
			r_nxt.aw_held = 1'b1;
			r_nxt.aw_idx = addr_idx(s_axi_awaddr_i);
			r_nxt.awready = 1'b0;
		end
		if (s_axi_wvalid_i && r_r.wready) begin
			r_nxt.w_held = 1'b1;
			r_nxt.wdata = s_axi_wdata_i;
			r_nxt.wstrb = s_axi_wstrb_i;
			r_nxt.wready = 1'b0;
		end
		if (r_r.bvalid && s_axi_bready_i) begin
			r_nxt.bvalid = 1'b0;
			r_nxt.awready = 1'b1;
			r_nxt.wready = 1'b1;
		end

		// Flags: a clear by software never beats a new event.
		if (do_write && wr_ok) begin
			case (r_r.aw_idx)
				IDX_CPU_POWER_CONTROL:
					r_nxt.cpu_power_control = 8'(merge({24'h000000, r_r.cpu_power_control},
						r_r.wdata, r_r.wstrb));
				IDX_INTERRUPT_SOURCE_1:
					r_nxt.intsrc = w1c(r_r.intsrc, r_r.wdata, r_r.wstrb);
				IDX_WAKE_FLAGS_BANK_A:
					r_nxt.fl_a = w1c(r_r.fl_a, r_r.wdata, r_r.wstrb);
				IDX_WAKE_FLAGS_BANK_B:
					r_nxt.fl_b = w1c(r_r.fl_b, r_r.wdata, r_r.wstrb);
				IDX_WAKE_FLAGS_HOST_PINS:
					r_nxt.fl_host = w1c(r_r.fl_host, r_r.wdata, r_r.wstrb);
				IDX_WAKE_FLAGS_PINS_LOW:
					r_nxt.fl_low = w1c(r_r.fl_low, r_r.wdata, r_r.wstrb);
				IDX_WAKE_FLAGS_PINS_MID:
					r_nxt.fl_mid = w1c(r_r.fl_mid, r_r.wdata, r_r.wstrb);
				IDX_WAKE_FLAGS_PINS_HIGH:
					r_nxt.fl_high = w1c(r_r.fl_high, r_r.wdata, r_r.wstrb);
				IDX_WAKE_FLAGS_FAN:
					r_nxt.fl_fan = w1c(r_r.fl_fan, r_r.wdata, r_r.wstrb);
				IDX_CLOCK_SELECT_CONTROL:
					r_nxt.clksel = 8'(merge({24'h000000, r_r.clksel},
						r_r.wdata, r_r.wstrb));
				IDX_SLEEP_ENTRY_FLAG:
					if (r_r.wstrb[0]) begin
						r_nxt.sleep_entry_flag = r_r.wdata[0];
					end
				IDX_WAKE_ENABLE:
					r_nxt.wake_en = 8'(merge({24'h000000, r_r.wake_en},
						r_r.wdata, r_r.wstrb));
				IDX_PIN_EDGE_SELECT:
					r_nxt.edge_sel = 22'(merge({10'h000, r_r.edge_sel},
						r_r.wdata, r_r.wstrb));
				default: ;
			endcase
		end
		if (do_write) begin
			r_nxt.aw_held = 1'b0;
			r_nxt.w_held = 1'b0;
			r_nxt.bvalid = 1'b1;
			r_nxt.bresp = !known_idx(r_r.aw_idx) ? RESP_DECERR :
				(wr_ok ? RESP_OKAY : RESP_SLVERR);
		end
		r_nxt.fl_a = r_nxt.fl_a | set_a;
		r_nxt.fl_b = r_nxt.fl_b | set_b;
		r_nxt.fl_host = r_nxt.fl_host | set_host;
		r_nxt.fl_low = r_nxt.fl_low | set_low;
		r_nxt.fl_mid = r_nxt.fl_mid | set_mid;
		r_nxt.fl_high = r_nxt.fl_high | set_high;
		r_nxt.fl_fan = r_nxt.fl_fan | set_fan;
		r_nxt.intsrc = r_nxt.intsrc | set_int;

		// Read channel: one word, answered the cycle after acceptance.
		if (s_axi_arvalid_i && r_r.arready) begin
			r_nxt.arready = 1'b0;
			r_nxt.rvalid = 1'b1;
			if (!known_idx(ar_idx)) begin
				r_nxt.rdata = 32'h00000000;
				r_nxt.rresp = RESP_DECERR;
			end else if (!main_ok &&
					ar_idx == IDX_WAKE_FLAGS_HOST_PINS) begin
				r_nxt.rdata = 32'h00000000;
				r_nxt.rresp = RESP_SLVERR;
			end else begin
				r_nxt.rdata = read_idx(r_r, ar_idx);
				r_nxt.rresp = RESP_OKAY;
			end
		end
		if (r_r.rvalid && s_axi_rready_i) begin
			r_nxt.rvalid = 1'b0;
			r_nxt.arready = 1'b1;
		end

		// Power-mode sequencer.
		case (r_r.st)
			ST_RUN: begin
				if (r_r.cpu_power_control[IDLE_BIT]) begin
					r_nxt.st = r_r.sleep_entry_flag ? ST_SLEEP : ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (enabled_irq_i) begin
					r_nxt.cpu_power_control[IDLE_BIT] = 1'b0;
					r_nxt.st = ST_RUN;
				end
			end
			ST_SLEEP: begin
				if (wake_req) begin
					r_nxt.st = ST_WAKE;
				end
			end
			ST_WAKE: begin
				r_nxt.cpu_power_control[IDLE_BIT] = 1'b0;
				r_nxt.sleep_entry_flag = 1'b0;
				r_nxt.st = ST_RUN;
			end
			default: r_nxt.st = ST_RUN;
		endcase
		// Wake restarts on the ring oscillator; firmware moves off it.
		if (r_nxt.st == ST_WAKE) begin
			r_nxt.clksel[RING_EN_BIT] = 1'b1;
			r_nxt.clksel[EXT_SRC_BIT] = 1'b0;
		end

		// Clock gates follow the next mode so they come from flops.
		r_nxt.core_clk_en = (r_nxt.st == ST_RUN) ||
			(r_nxt.st == ST_WAKE);
		r_nxt.periph_clk_en = (r_nxt.st != ST_SLEEP);
		r_nxt.ring_osc_en = r_nxt.clksel[RING_EN_BIT] &&
			(r_nxt.st != ST_SLEEP);
		r_nxt.xtal_osc_en = (r_nxt.st != ST_SLEEP);
		r_nxt.pin_hold = (r_nxt.st == ST_IDLE) ||
			(r_nxt.st == ST_SLEEP);
	end

	// Standby power-on reset loads every register with its reset value and ends any mode.
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			r_r <= '0;
			r_r.st <= ST_RUN;
			r_r.awready <= 1'b1;
			r_r.wready <= 1'b1;
			r_r.arready <= 1'b1;
			r_r.cpu_power_control <= RST_CPU_POWER_CONTROL;
			r_r.clksel <= RST_CLOCK_SELECT;
			r_r.wake_en <= RST_WAKE_ENABLE;
			r_r.edge_sel <= RST_EDGE_SELECT;
			r_r.core_clk_en <= 1'b1;
			r_r.periph_clk_en <= 1'b1;
			r_r.xtal_osc_en <= 1'b1;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign s_axi_awready_o = r_r.awready;
	assign s_axi_wready_o = r_r.wready;
	assign s_axi_bresp_o = r_r.bresp;
	assign s_axi_bvalid_o = r_r.bvalid;
	assign s_axi_arready_o = r_r.arready;
	assign s_axi_rdata_o = r_r.rdata;
	assign s_axi_rresp_o = r_r.rresp;
	assign s_axi_rvalid_o = r_r.rvalid;
	assign core_clk_en_o = r_r.core_clk_en;
	assign periph_clk_en_o = r_r.periph_clk_en;
	assign ring_osc_en_o = r_r.ring_osc_en;
	assign xtal_osc_en_o = r_r.xtal_osc_en;
	assign clk_src_ext_o = r_r.clksel[EXT_SRC_BIT];
	assign pin_hold_o = r_r.pin_hold;
	assign idle_o = r_r.st[1];
	assign sleep_o = r_r.st[2];

endmodule : pwk_power_wake

/* File: tb/pwk_power_wake_checker.sv */
// Port assertions of the power and wake controller.
module pwk_power_wake_checker
	import pwk_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rstn_i,
	// Bus handshakes.
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// Interrupt and wake sources.
	input wire logic enabled_irq_i,
	input wire logic rtc_alarm_wake_i,
	input wire logic hibernation_timer_wake_i,
	input wire logic acpi_status_wake_i,
	input wire logic acpi_enable_wake_i,
	input wire logic acpi_control_wake_i,
	input wire logic fan1_slow_wake_i,
	input wire logic fan2_slow_wake_i,
	input wire logic smbus1_data_pin_i,
	input wire logic smbus2_data_pin_i,
	input wire logic [7:0] key_scan_inputs_i,
	input wire logic [NPINS-1:0] gpio_pins_i,
	input wire logic [3:0] host_pins_i,
	// Clock and power controls.
	input wire logic core_clk_en_o,
	input wire logic periph_clk_en_o,
	input wire logic ring_osc_en_o,
	input wire logic xtal_osc_en_o,
	input wire logic clk_src_ext_o,
	input wire logic pin_hold_o,
	input wire logic idle_o,
	input wire logic sleep_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	// Edges with all wake sources quiet, saturating.
	logic [35:0] pins_r;
	logic [2:0] quiet_r;
	wire logic [35:0] pins_w = {smbus1_data_pin_i, smbus2_data_pin_i,
		key_scan_inputs_i, gpio_pins_i, host_pins_i};
	wire logic src_w = rtc_alarm_wake_i | hibernation_timer_wake_i
		| acpi_status_wake_i | acpi_enable_wake_i | acpi_control_wake_i
		| fan1_slow_wake_i | fan2_slow_wake_i;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pins_r <= '0;
			quiet_r <= 3'h0;
		end else begin
			pins_r <= pins_w;
			if (pins_w != pins_r || src_w)
				quiet_r <= 3'h0;
			else if (quiet_r != 3'h7)
				quiet_r <= quiet_r + 3'h1;
		end
	end

	sequence s_wr;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	sequence s_leave;
		sleep_o ##1 !sleep_o;
	endsequence

	property p_idle_clk;
		idle_o |-> !core_clk_en_o && periph_clk_en_o && xtal_osc_en_o;
	endproperty
	a_idle_clk: assert property (p_idle_clk) else $error("idle clocks");
	property p_hold;
		(idle_o || sleep_o) |-> pin_hold_o;
	endproperty
	a_hold: assert property (p_hold) else $error("pins not held");
	property p_irq_exit;
		idle_o && enabled_irq_i && s_axi_awready_o |=> !idle_o && core_clk_en_o;
	endproperty
	a_irq_exit: assert property (p_irq_exit) else $error("idle kept");
	property p_por;
		$rose(rstn_i) |-> !idle_o && !sleep_o && core_clk_en_o
			&& !ring_osc_en_o && clk_src_ext_o;
	endproperty
	a_por: assert property (p_por) else $error("reset state");
	property p_sleep_clk;
		sleep_o |-> !(core_clk_en_o || periph_clk_en_o || ring_osc_en_o
			|| xtal_osc_en_o);
	endproperty
	a_sleep_clk: assert property (p_sleep_clk) else $error("clock on");
	property p_stay;
		sleep_o && $past(sleep_o) && quiet_r == 3'h7 |=> sleep_o;
	endproperty
	a_stay: assert property (p_stay) else $error("spurious wake");
	property p_wake;
		s_leave |-> core_clk_en_o && ring_osc_en_o && !clk_src_ext_o;
	endproperty
	a_wake: assert property (p_wake) else $error("wake clocks");
	property p_wr;
		s_wr |-> ##[1:3] s_axi_bvalid_o;
	endproperty
	a_wr: assert property (p_wr) else $error("no write response");
	property p_b_hold;
		s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o
			&& $stable(s_axi_bresp_o);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
	property p_rd;
		s_axi_arvalid_i && s_axi_arready_o |-> ##[1:2] s_axi_rvalid_o;
	endproperty
	a_rd: assert property (p_rd) else $error("no read response");
	property p_r_hold;
		s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
			&& $stable(s_axi_rdata_o);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
endmodule : pwk_power_wake_checker

bind pwk_power_wake pwk_power_wake_checker i_pwk_power_wake_checker (.*);

/* File: tb/pwk_src_model.sv */
// Wake event sources, core interrupt and supply facing the controller.
module pwk_src_model
	import pwk_pkg::*;
(
	// Clock.
	input wire logic clk_i,
	// Interrupt and main supply.
	output logic irq_o = 1'b0,
	output logic main_o = 1'b1,
	// Order: rtc, hib, status, enable, control, fan1, fan2.
	output logic [6:0] src_o = 7'h00,
	// Pins; SMBus data and key scan lines idle high on pull-ups.
	output logic smb1_o = 1'b1,
	output logic smb2_o = 1'b1,
	output logic [7:0] ksi_o = 8'hff,
	output logic [NPINS-1:0] gpio_o = '1,
	output logic [3:0] host_o = 4'h0
);
	timeunit 1ns;
	timeprecision 1ps;
	task automatic pulse(input int k);
		@(posedge clk_i);
		src_o[k] <= 1'b1;
		@(posedge clk_i);
		src_o[k] <= 1'b0;
	endtask : pulse

	task automatic pins(input logic a, input logic b, input logic [7:0] c,
			input logic [NPINS-1:0] d, input logic [3:0] e);
		@(posedge clk_i);
		smb1_o <= a;
		smb2_o <= b;
		ksi_o <= c;
		gpio_o <= d;
		host_o <= e;
	endtask : pins

	task automatic ctl(input logic i, input logic m);
		@(posedge clk_i);
		irq_o <= i;
		main_o <= m;
	endtask : ctl
endmodule : pwk_src_model

/* File: tb/tb_top.sv */
// Self-checking bench of the power and wake controller.
module tb_top import pwk_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_i = 1'b0, rstn_i = 1'b0;
	logic [17:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
	logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o;
	logic [3:0] s_axi_wstrb_i = 4'hf;
	logic s_axi_awvalid_i = '0, s_axi_wvalid_i = '0, s_axi_bready_i = '0;
	logic s_axi_arvalid_i = '0, s_axi_rready_i = '0;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
	logic s_axi_arready_o, s_axi_rvalid_o;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
	logic core_clk_en_o, periph_clk_en_o, ring_osc_en_o, xtal_osc_en_o;
	logic clk_src_ext_o, pin_hold_o, idle_o, sleep_o;
	logic enabled_irq_i, smbus1_data_pin_i, smbus2_data_pin_i;
	logic main_supply_good_i;
	logic [7:0] key_scan_inputs_i;
	logic [NPINS-1:0] gpio_pins_i;
	logic [3:0] host_pins_i;
	logic [6:0] src;
	logic rtc_alarm_wake_i, hibernation_timer_wake_i, acpi_status_wake_i;
	logic acpi_enable_wake_i, acpi_control_wake_i;
	logic fan1_slow_wake_i, fan2_slow_wake_i;
	int error_cnt = 0, compares = 0;
	logic [15:0] ev_idx [7] = '{IDX_WAKE_FLAGS_BANK_B, IDX_WAKE_FLAGS_BANK_B,
		IDX_WAKE_FLAGS_BANK_A, IDX_WAKE_FLAGS_BANK_A, IDX_WAKE_FLAGS_BANK_A,
		IDX_WAKE_FLAGS_FAN, IDX_WAKE_FLAGS_FAN};
	logic [7:0] ev_val [7] = '{8'h01, 8'h04, 8'h20, 8'h40, 8'h80,
		8'h01, 8'h02};
	logic [15:0] clr_idx [6] = '{IDX_WAKE_FLAGS_BANK_A, IDX_WAKE_FLAGS_BANK_B,
		IDX_WAKE_FLAGS_HOST_PINS, IDX_WAKE_FLAGS_PINS_LOW,
		IDX_WAKE_FLAGS_PINS_HIGH, IDX_INTERRUPT_SOURCE_1};

	assign {fan2_slow_wake_i, fan1_slow_wake_i, acpi_control_wake_i,
		acpi_enable_wake_i, acpi_status_wake_i, hibernation_timer_wake_i,
		rtc_alarm_wake_i} = src;

	pwk_power_wake i_pwk_power_wake (.*);

	pwk_src_model i_pwk_src_model (
		.clk_i(clk_i),
		.irq_o(enabled_irq_i),
		.main_o(main_supply_good_i),
		.src_o(src),
		.smb1_o(smbus1_data_pin_i),
		.smb2_o(smbus2_data_pin_i),
		.ksi_o(key_scan_inputs_i),
		.gpio_o(gpio_pins_i),
		.host_o(host_pins_i)
	);

	always #10 clk_i = ~clk_i;

	task automatic summarize();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize

	task automatic chk(input string nm, input logic [31:0] got,
			input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic tmo();
		error_cnt++;
		$display("[FAIL] wait expected done seen timeout");
		summarize();
	endtask : tmo

	task automatic cyc(input int k);
		repeat (k) @(posedge clk_i);
	endtask : cyc

	task automatic wr(input logic [15:0] idx, input logic [31:0] d,
			input logic [1:0] er = RESP_OKAY);
		int n;
		@(posedge clk_i);
		s_axi_awaddr_i <= {idx, 2'b00};
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge clk_i);
			if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
			if (s_axi_bvalid_o === 1'b1) break;
		end
		s_axi_bready_i <= 1'b0;
		if (n == 40) tmo();
		chk($sformatf("bresp %h", idx), {30'h0, s_axi_bresp_o}, {30'h0, er});
	endtask : wr

	task automatic rd(input logic [15:0] idx, input logic [31:0] ed,
			input logic [1:0] er = RESP_OKAY);
		int n;
		@(posedge clk_i);
		s_axi_araddr_i <= {idx, 2'b00};
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge clk_i);
			if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
			if (s_axi_rvalid_o === 1'b1) break;
		end
		s_axi_rready_i <= 1'b0;
		if (n == 40) tmo();
		chk($sformatf("rdata %h", idx), s_axi_rdata_o, ed);
		chk($sformatf("rresp %h", idx), {30'h0, s_axi_rresp_o}, {30'h0, er});
	endtask : rd

	task automatic wait_st(input logic [1:0] want);
		int n;
		for (n = 0; n < 60 && {idle_o, sleep_o} !== want; n++)
			@(posedge clk_i);
		if (n == 60) tmo();
	endtask : wait_st

	initial begin
		logic [NPINS-1:0] g;
		g = '1;
		repeat (4) @(posedge clk_i);
		rstn_i <= 1'b1;
		cyc(6);
		rd(IDX_CPU_POWER_CONTROL, 32'h0);
		rd(IDX_CLOCK_SELECT_CONTROL, 32'h20);
		rd(IDX_WAKE_ENABLE, 32'hff);
		rd(IDX_POWER_STATUS, 32'h11);
		rd(16'h0001, 32'h0, RESP_DECERR);
		wr(16'h0001, 32'h5, RESP_DECERR);
		wr(IDX_CPU_POWER_CONTROL, 32'h1);
		wait_st(2'b10);
		cyc(3);
		chk("idle clk", {29'h0, core_clk_en_o, periph_clk_en_o, idle_o}, 32'h3);
		chk("idle hold", {31'h0, pin_hold_o}, 32'h1);
		i_pwk_src_model.ctl(1'b1, 1'b1);
		wait_st(2'b00);
		i_pwk_src_model.ctl(1'b0, 1'b1);
		rd(IDX_CPU_POWER_CONTROL, 32'h0);
		for (int k = 0; k < 7; k++) begin
			i_pwk_src_model.pulse(k);
			cyc(4);
			rd(ev_idx[k], ev_val[k]);
			wr(ev_idx[k], 32'hff);
			rd(ev_idx[k], 32'h0);
		end
		i_pwk_src_model.pins(1'b0, 1'b1, 8'hff, g, 4'h0);
		cyc(5);
		rd(IDX_WAKE_FLAGS_BANK_A, 32'h10);
		i_pwk_src_model.pins(1'b0, 1'b0, 8'hff, g, 4'h0);
		cyc(5);
		rd(IDX_WAKE_FLAGS_BANK_A, 32'h18);
		i_pwk_src_model.pins(1'b1, 1'b1, 8'hdf, g, 4'h0);
		cyc(5);
		rd(IDX_WAKE_FLAGS_BANK_A, 32'h18);
		rd(IDX_WAKE_FLAGS_BANK_B, 32'h02);
		wr(IDX_PIN_EDGE_SELECT, 32'h0004_0000);
		g[0] = 1'b0;
		g[3] = 1'b0;
		g[18] = 1'b0;
		i_pwk_src_model.pins(1'b1, 1'b1, 8'hff, g, 4'h9);
		cyc(5);
		rd(IDX_WAKE_FLAGS_PINS_LOW, 32'h04);
		rd(IDX_INTERRUPT_SOURCE_1, 32'h08);
		rd(IDX_WAKE_FLAGS_PINS_HIGH, 32'h00);
		rd(IDX_WAKE_FLAGS_HOST_PINS, 32'h09);
		wr(IDX_WAKE_FLAGS_HOST_PINS, 32'hff);
		g = '1;
		i_pwk_src_model.pins(1'b1, 1'b1, 8'hff, g, 4'h1);
		cyc(5);
		rd(IDX_WAKE_FLAGS_PINS_HIGH, 32'h80);
		rd(IDX_WAKE_FLAGS_HOST_PINS, 32'h08);
		wr(IDX_WAKE_FLAGS_HOST_PINS, 32'hff);
		i_pwk_src_model.ctl(1'b0, 1'b0);
		cyc(4);
		rd(IDX_WAKE_FLAGS_HOST_PINS, 32'h0, RESP_SLVERR);
		i_pwk_src_model.pins(1'b1, 1'b1, 8'hff, g, 4'h3);
		cyc(5);
		i_pwk_src_model.ctl(1'b0, 1'b1);
		cyc(4);
		rd(IDX_WAKE_FLAGS_HOST_PINS, 32'h02);
		foreach (clr_idx[i])
			wr(clr_idx[i], 32'hff);
		// Sleep with the key bank masked, woken by an SMBus line.
		wr(IDX_CLOCK_SELECT_CONTROL, 32'h10);
		cyc(2);
		chk("ring on", {30'h0, ring_osc_en_o, clk_src_ext_o}, 32'h2);
		wr(IDX_WAKE_ENABLE, 32'hfd);
		wr(IDX_SLEEP_ENTRY_FLAG, 32'h1);
		wr(IDX_CPU_POWER_CONTROL, 32'h1);
		wait_st(2'b01);
		cyc(1);
		chk("sleep clk", {28'h0, core_clk_en_o, periph_clk_en_o,
			ring_osc_en_o, xtal_osc_en_o}, 32'h0);
		i_pwk_src_model.pins(1'b1, 1'b1, 8'hfe, g, 4'h3);
		cyc(12);
		chk("asleep", {31'h0, sleep_o}, 32'h1);
		i_pwk_src_model.pins(1'b0, 1'b1, 8'hfe, g, 4'h3);
		wait_st(2'b00);
		chk("woken", {29'h0, core_clk_en_o, ring_osc_en_o, clk_src_ext_o},
			32'h6);
		rd(IDX_CPU_POWER_CONTROL, 32'h0);
		rd(IDX_SLEEP_ENTRY_FLAG, 32'h0);
		wr(IDX_CLOCK_SELECT_CONTROL, 32'h20);
		cyc(2);
		chk("ext clk", {30'h0, ring_osc_en_o, clk_src_ext_o}, 32'h1);
		wr(IDX_CPU_POWER_CONTROL, 32'h1);
		wait_st(2'b10);
		rstn_i <= 1'b0;
		cyc(2);
		rstn_i <= 1'b1;
		cyc(2);
		chk("reset idle", {30'h0, idle_o, core_clk_en_o}, 32'h1);
		rd(IDX_CPU_POWER_CONTROL, 32'h0);
		rd(IDX_WAKE_ENABLE, 32'hff);
		summarize();
	end
endmodule : tb_top
